/* File: bench/emu_bus_model.sv */
// emulation processor bus model: presents traced bus states to the block
// assumes: driven from the bench by task calls made at a falling edge
`timescale 1ns/1ps
`default_nettype none
module emu_bus_model
  import trc_pkg::*;
(
  input wire logic clk_in,
  output logic running_out,
  output logic valid_out,
  output logic [trc_pkg::ADDR_W-1:0] addr_out,
  output logic [trc_pkg::DATA_W-1:0] data_out,
  output logic [trc_pkg::STAT_W-1:0] stat_out
);
  import trc_pkg::*;

  // ----------------------------------------------------------------------
  // idle bus: nothing valid, processor running
  // ----------------------------------------------------------------------
  initial begin
    running_out = 1'b1;
    valid_out = 1'b0;
    addr_out = '0;
    data_out = '0;
    stat_out = '0;
  end

  // processor run level, lets the bench stop execution
  task automatic set_run(input logic r);
    running_out = r;
  endtask

  // one bus state for one cycle, then released lines show the inverse
  task automatic send(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [STAT_W-1:0] s);
    valid_out = 1'b1;
    addr_out = a;
    data_out = d;
    stat_out = s;
    @(negedge clk_in);
    valid_out = 1'b0;
    addr_out = ~a; // stale value never passes for a live one
    data_out = ~d;
    stat_out = ~s;
    @(negedge clk_in); // idle cycle keeps two states apart
  endtask
endmodule
`default_nettype wire

/* File: bench/trace_qualifier_run_control_tb.sv */
// self-checking bench for the trace qualifier and run control
// assumes: trc_pkg compiled first, memory depth shortened to 4
`timescale 1ns/1ps
`default_nettype none
module trace_qualifier_run_control_tb;
  import trc_pkg::*;
  localparam int DEPTH = 4;
  logic clk, rst, arm, pat_we, pat_neq, range_we, expr_we, s1_nor, s2_nor;
  logic inter_and, emu_run, valid, ce;
  logic [2:0] cmd, pat_idx; // cmd bits: reset, begin, halt
  logic [ADDR_W-1:0] addr, r_lo, r_hi;
  logic [DATA_W-1:0] data;
  logic [STAT_W-1:0] stat;
  logic [STATE_W-1:0] pat_val, pat_mask, rd_data;
  logic [SET1_W-1:0] s1_sel;
  logic [SET2_W-1:0] s2_sel;
  logic [1:0] rd_addr;
  logic running, complete, trig, drive;
  logic [2:0] count;
  int error_cnt = 0;
  int n_checks = 0;

  // ----------------------------------------------------------------------
  // clock, design and bus model
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  trace_qualifier_run_control #(.DEPTH(DEPTH)) uut (
    .REF_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .CMD_RESET_IN(cmd[2]), .CMD_BEGIN_IN(cmd[1]), .CMD_HALT_IN(cmd[0]),
    .EMU_RUNNING_IN(emu_run), .STATE_VALID_IN(valid), .ADDR_IN(addr),
    .DATA_IN(data), .STAT_IN(stat), .ARM_IN(arm), .PAT_WE_IN(pat_we),
    .PAT_IDX_IN(pat_idx), .PAT_VALUE_IN(pat_val), .PAT_MASK_IN(pat_mask),
    .PAT_NEQ_IN(pat_neq), .RANGE_WE_IN(range_we), .RANGE_LO_IN(r_lo),
    .RANGE_HI_IN(r_hi), .EXPR_WE_IN(expr_we), .SET1_SEL_IN(s1_sel),
    .SET1_NOR_IN(s1_nor), .SET2_SEL_IN(s2_sel), .SET2_NOR_IN(s2_nor),
    .INTER_AND_IN(inter_and), .RD_ADDR_IN(rd_addr), .RUNNING_OUT(running),
    .COMPLETE_OUT(complete), .TRIG_FOUND_OUT(trig), .TRIG_DRIVE_OUT(drive),
    .STORED_COUNT_OUT(count), .RD_DATA_OUT(rd_data));

  emu_bus_model bus (.clk_in(clk), .running_out(emu_run), .valid_out(valid),
    .addr_out(addr), .data_out(data), .stat_out(stat));

  // ----------------------------------------------------------------------
  // compares, drivers and closing
  // ----------------------------------------------------------------------
  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %b, seen %b", name, exp, got);
    end
  endtask

  task automatic chk_word(input string name, input logic [STATE_W-1:0] exp,
                          input logic [STATE_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // one-cycle command pulse
  task automatic pulse(input logic [2:0] c);
    cmd = c;
    @(negedge clk);
    cmd = 3'h0;
    @(negedge clk); // idle cycle between two pulses
  endtask

  task automatic pat_wr(input logic [2:0] i, input logic [STATE_W-1:0] v,
                        input logic [STATE_W-1:0] m, input logic neq);
    {pat_we, pat_idx, pat_val, pat_mask, pat_neq} = {1'b1, i, v, m, neq};
    @(negedge clk);
    pat_we = 1'b0;
    @(negedge clk); // idle cycle between two writes
  endtask

  task automatic finish_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // default spec: trigger at once, fill memory, complete, read, halt
  task automatic t_capture;
    chk_bit("idle running", 1'b0, running);
    chk_word("idle count", '0, STATE_W'(count));
    pulse(3'h2);
    chk_bit("running", 1'b1, running);
    for (int i = 0; i < DEPTH; i++) begin
      bus.send(24'h200 + 24'(i), 16'h1000 + 16'(i), 8'h5a);
      chk_word("count", STATE_W'(i + 1), STATE_W'(count));
      chk_bit("trig", 1'b1, trig);
    end
    for (int k = 0; k < 3 && complete !== 1'b1; k++) @(negedge clk);
    chk_bit("complete", 1'b1, complete);
    chk_bit("running at end", 1'b0, running);
    bus.send(24'h300, 16'h0, 8'h0);
    chk_word("count after end", STATE_W'(DEPTH), STATE_W'(count));
    rd_addr = 2'h0;
    @(negedge clk);
    chk_word("word 0", {8'h5a, 16'h1000, 24'h200}, rd_data);
    rd_addr = 2'h3;
    @(negedge clk);
    chk_word("word 3", {8'h5a, 16'h1003, 24'h203}, rd_data);
    pulse(3'h1);
    chk_bit("complete halted", 1'b0, complete);
    chk_bit("drive halted", 1'b0, drive);
  endtask

  // no trigger yet, processor stopped, then trigger with memory not full
  task automatic t_pretrig;
    pat_wr(3'h0, {8'h0, 16'h1234, 24'h100}, {8'h0, 16'hffff, 24'hffffff}, 0);
    pat_wr(3'h4, {8'h0, 16'h1234, 24'h100}, {8'h0, 16'hffff, 24'hffffff}, 1);
    {range_we, r_lo, r_hi} = {1'b1, 24'h100, 24'h1ff};
    @(negedge clk);
    range_we = 1'b0;
    pulse(3'h2);
    bus.send(24'h300, 16'h1234, 8'h0);
    bus.set_run(1'b0);
    bus.send(24'h100, 16'h1234, 8'h0);
    chk_bit("no trig", 1'b0, trig);
    chk_bit("running no trig", 1'b1, running);
    chk_word("count no trig", '0, STATE_W'(count));
    bus.set_run(1'b1);
    bus.send(24'h100, 16'h1234, 8'h0);
    chk_bit("drive", 1'b1, drive);
    chk_bit("running partial", 1'b1, running);
    chk_word("count partial", STATE_W'(1), STATE_W'(count));
    pulse(3'h1);
    chk_bit("halt running", 1'b0, running);
    chk_bit("halt drive", 1'b0, drive);
  endtask

  // one qualifier expression against one bus state
  task automatic q_case(input logic [5:0] s1, input logic n1,
                        input logic [4:0] s2, input logic n2, input logic ia,
                        input logic a, input logic [15:0] d, input logic exp);
    {expr_we, s1_sel, s1_nor, s2_sel, s2_nor, inter_and} =
      {1'b1, s1, n1, s2, n2, ia};
    arm = a;
    @(negedge clk);
    expr_we = 1'b0;
    pulse(3'h2);
    bus.send(24'h100, d, 8'h0);
    chk_bit("qualified trig", exp, trig);
    pulse(3'h1);
  endtask

  // a: addr 100 and data 1234 equal; e: same, not-equal; r: 100..1ff
  task automatic t_expr;
    q_case(6'h04, 0, 5'h00, 0, 0, 0, 16'h1234, 1'b1);
    q_case(6'h04, 1, 5'h00, 0, 0, 0, 16'h1234, 1'b0);
    q_case(6'h04, 0, 5'h00, 0, 0, 0, 16'h0000, 1'b0);
    q_case(6'h04, 0, 5'h01, 0, 1, 0, 16'h1234, 1'b0);
    q_case(6'h04, 0, 5'h01, 1, 1, 0, 16'h1234, 1'b1);
    q_case(6'h01, 0, 5'h10, 0, 1, 1, 16'h1234, 1'b1);
    q_case(6'h01, 0, 5'h10, 0, 1, 0, 16'h1234, 1'b0);
    q_case(6'h02, 0, 5'h00, 0, 0, 0, 16'h1234, 1'b0);
    q_case(6'h04, 1, 5'h01, 1, 0, 0, 16'h1234, 1'b1);
    q_case(6'h04, 1, 5'h01, 0, 0, 0, 16'h1234, 1'b0);
    q_case(6'h06, 1, 5'h00, 0, 0, 0, 16'h0000, 1'b1);
  endtask

  // trace reset stops a run and brings back the match-all default
  task automatic t_reset;
    pulse(3'h2);
    pulse(3'h4);
    chk_bit("reset running", 1'b0, running);
    pulse(3'h2);
    bus.send(24'h777, 16'h0, 8'h0);
    chk_bit("default trig", 1'b1, trig);
    // a halt given while the enable is low must be ignored
    ce = 1'b0;
    pulse(3'h1);
    chk_bit("frozen drive", 1'b1, drive);
    ce = 1'b1;
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    {rst, cmd, arm, pat_we, pat_idx, pat_val, pat_mask, pat_neq} = '0;
    {range_we, r_lo, r_hi, expr_we, s1_sel, s1_nor} = '0;
    {s2_sel, s2_nor, inter_and, rd_addr} = '0;
    ce = 1'b1;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_capture();
    t_pretrig();
    t_expr();
    t_reset();
    finish_test();
  end

  initial begin
    #20us;
    error_cnt++;
    finish_test();
  end
endmodule
`default_nettype wire

/* File: logic/trace_qualifier_run_control.sv */
// trace qualifier and run control with its trace memory
// assumes: all inputs synchronous to REF_CLK_IN, commands are pulses
//
// Overview of operation
// - set two holds patterns e-h together with the arm input.
// - the two set results are joined by a selectable AND or OR only.
// - each set combines its chosen members with one operator, OR or NOR.
// - the within-set operator never reaches across the two sets.
// - a single member NORed with itself gives its inverse.
// - set results are formed first, then the between-set operator.
// - each pattern has an equal or not-equal sense for inversion.
// - the trace reset command restores the default specification.
// - states are stored only while running and the processor runs.
// - complete shows only after trigger and a full trace memory.
// - running stays shown before trigger and while memory still fills.
// - the stored state count is readable and is zero before trigger.
// - halt stops the trace and drops the trigger-driven output.
// - a pattern matches only when every label comparison matches.
`timescale 1ns/1ps
`default_nettype none
module trace_qualifier_run_control
  import trc_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int AW = $clog2(DEPTH),
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic CMD_RESET_IN,
  input wire logic CMD_BEGIN_IN,
  input wire logic CMD_HALT_IN,
  input wire logic EMU_RUNNING_IN,
  input wire logic STATE_VALID_IN,
  input wire logic [trc_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [trc_pkg::DATA_W-1:0] DATA_IN,
  input wire logic [trc_pkg::STAT_W-1:0] STAT_IN,
  input wire logic ARM_IN,
  input wire logic PAT_WE_IN,
  input wire logic [trc_pkg::PAT_IDX_W-1:0] PAT_IDX_IN,
  input wire logic [trc_pkg::STATE_W-1:0] PAT_VALUE_IN,
  input wire logic [trc_pkg::STATE_W-1:0] PAT_MASK_IN,
  input wire logic PAT_NEQ_IN,
  input wire logic RANGE_WE_IN,
  input wire logic [trc_pkg::ADDR_W-1:0] RANGE_LO_IN,
  input wire logic [trc_pkg::ADDR_W-1:0] RANGE_HI_IN,
  input wire logic EXPR_WE_IN,
  input wire logic [trc_pkg::SET1_W-1:0] SET1_SEL_IN,
  input wire logic SET1_NOR_IN,
  input wire logic [trc_pkg::SET2_W-1:0] SET2_SEL_IN,
  input wire logic SET2_NOR_IN,
  input wire logic INTER_AND_IN,
  input wire logic [AW-1:0] RD_ADDR_IN,
  output logic RUNNING_OUT,
  output logic COMPLETE_OUT,
  output logic TRIG_FOUND_OUT,
  output logic TRIG_DRIVE_OUT,
  output logic [CNT_W-1:0] STORED_COUNT_OUT,
  output logic [trc_pkg::STATE_W-1:0] RD_DATA_OUT
);
  import trc_pkg::*;

  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  // --------------------------------------------------------------------
  // decoding shared by several resources
  // --------------------------------------------------------------------
  function automatic logic pat_match(input logic [STATE_W-1:0] s,
                                     input logic [STATE_W-1:0] v,
                                     input logic [STATE_W-1:0] m);
    logic [STATE_W-1:0] d;
    d = (s ^ v) & m;
    // every label must compare for the pattern to match
    pat_match = ~|d[DATA_LSB-1:ADDR_LSB] & ~|d[STAT_LSB-1:DATA_LSB] &
                ~|d[STATE_W-1:STAT_LSB];
  endfunction

  function automatic logic set_result(input logic [SET1_W-1:0] members,
                                      input logic [SET1_W-1:0] sel,
                                      input logic use_nor);
    logic any;
    any = |(members & sel);
    set_result = use_nor ? ~any : any;
  endfunction

  // --------------------------------------------------------------------
  // trace specification
  // --------------------------------------------------------------------
  logic [STATE_W-1:0] pat_val_reg [N_PAT];
  logic [STATE_W-1:0] pat_mask_reg [N_PAT];
  logic [N_PAT-1:0] pat_neq_reg;
  logic [ADDR_W-1:0] range_lo_reg;
  logic [ADDR_W-1:0] range_hi_reg;
  logic [SET1_W-1:0] set1_sel_reg;
  logic set1_nor_reg;
  logic [SET2_W-1:0] set2_sel_reg;
  logic set2_nor_reg;
  logic inter_and_reg;

  // pattern table, reset command returns defaults
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < N_PAT; i++) begin
        pat_val_reg[i] <= PAT_VAL_RST;
        pat_mask_reg[i] <= PAT_MASK_RST;
      end
      pat_neq_reg <= PAT_NEQ_RST;
    end else if (CE_IN) begin
      if (CMD_RESET_IN) begin
        for (int i = 0; i < N_PAT; i++) begin
          pat_val_reg[i] <= PAT_VAL_RST;
          pat_mask_reg[i] <= PAT_MASK_RST;
        end
        pat_neq_reg <= PAT_NEQ_RST;
      end else if (PAT_WE_IN) begin
        pat_val_reg[PAT_IDX_IN] <= PAT_VALUE_IN;
        pat_mask_reg[PAT_IDX_IN] <= PAT_MASK_IN;
        pat_neq_reg[PAT_IDX_IN] <= PAT_NEQ_IN;
      end
    end
  end

  // range bounds and expression operators
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      range_lo_reg <= RANGE_LO_RST;
      range_hi_reg <= RANGE_HI_RST;
      set1_sel_reg <= SET1_SEL_RST;
      set1_nor_reg <= SET1_NOR_RST;
      set2_sel_reg <= SET2_SEL_RST;
      set2_nor_reg <= SET2_NOR_RST;
      inter_and_reg <= INTER_AND_RST;
    end else if (CE_IN) begin
      if (CMD_RESET_IN) begin
        range_lo_reg <= RANGE_LO_RST;
        range_hi_reg <= RANGE_HI_RST;
        set1_sel_reg <= SET1_SEL_RST;
        set1_nor_reg <= SET1_NOR_RST;
        set2_sel_reg <= SET2_SEL_RST;
        set2_nor_reg <= SET2_NOR_RST;
        inter_and_reg <= INTER_AND_RST;
      end else begin
        if (RANGE_WE_IN) begin
          range_lo_reg <= RANGE_LO_IN;
          range_hi_reg <= RANGE_HI_IN;
        end
        if (EXPR_WE_IN) begin
          set1_sel_reg <= SET1_SEL_IN;
          set1_nor_reg <= SET1_NOR_IN;
          set2_sel_reg <= SET2_SEL_IN;
          set2_nor_reg <= SET2_NOR_IN;
          inter_and_reg <= INTER_AND_IN;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // qualifier evaluation
  // --------------------------------------------------------------------
  logic [STATE_W-1:0] cur_state;
  logic [N_PAT-1:0] pat_hit;
  logic range_hit;
  logic [SET1_W-1:0] set1_members;
  logic [SET1_W-1:0] set2_members;
  logic set1_res;
  logic set2_res;
  logic qual;

  assign cur_state = {STAT_IN, DATA_IN, ADDR_IN};

  // one comparator per pattern, sense flipped for not-equal
  for (genvar g = 0; g < N_PAT; g++) begin : g_pat
    assign pat_hit[g] = pat_match(cur_state, pat_val_reg[g],
                                  pat_mask_reg[g]) ^ pat_neq_reg[g];
  end

  assign range_hit = (ADDR_IN >= range_lo_reg) && (ADDR_IN <= range_hi_reg);
  assign set1_members = {pat_hit[3:0], ~range_hit, range_hit};
  assign set2_members = {1'b0, ARM_IN, pat_hit[7:4]};
  // each set reduced on its own before the sets meet
  assign set1_res = set_result(set1_members, set1_sel_reg,
                               set1_nor_reg);
  assign set2_res = set_result(set2_members, {1'b0, set2_sel_reg},
                               set2_nor_reg);
  assign qual = inter_and_reg ? (set1_res & set2_res)
                              : (set1_res | set2_res);

  // --------------------------------------------------------------------
  // run control
  // --------------------------------------------------------------------
  run_state_t state_reg;
  logic capture;
  logic store;
  logic stop_cmd;

  assign stop_cmd = CMD_RESET_IN | CMD_HALT_IN;
  assign capture = (state_reg == ST_RUN) && EMU_RUNNING_IN &&
                   STATE_VALID_IN && !stop_cmd && !CMD_BEGIN_IN;
  assign store = capture && (TRIG_FOUND_OUT || qual);

  // lifecycle: reset and halt win over begin
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
    end else if (CE_IN) begin
      if (stop_cmd) begin
        state_reg <= ST_IDLE;
      end else if (CMD_BEGIN_IN) begin
        state_reg <= ST_RUN;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            state_reg <= ST_IDLE;
          end
          ST_RUN: begin
            if (store && STORED_COUNT_OUT == FULL_CNT - 1'b1) begin
              state_reg <= ST_DONE;
            end
          end
          ST_DONE: begin
            state_reg <= ST_DONE;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // status flags follow the state
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      RUNNING_OUT <= 1'b0;
      COMPLETE_OUT <= 1'b0;
    end else if (CE_IN) begin
      if (stop_cmd) begin
        RUNNING_OUT <= 1'b0;
        COMPLETE_OUT <= 1'b0;
      end else if (CMD_BEGIN_IN) begin
        RUNNING_OUT <= 1'b1;
        COMPLETE_OUT <= 1'b0;
      end else if (store && STORED_COUNT_OUT == FULL_CNT - 1'b1) begin
        RUNNING_OUT <= 1'b0;
        COMPLETE_OUT <= 1'b1;
      end
    end
  end

  // trigger found and the trigger-driven output
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      TRIG_FOUND_OUT <= 1'b0;
      TRIG_DRIVE_OUT <= 1'b0;
    end else if (CE_IN) begin
      if (stop_cmd || CMD_BEGIN_IN) begin
        TRIG_FOUND_OUT <= 1'b0;
        TRIG_DRIVE_OUT <= 1'b0;
      end else if (capture && qual) begin
        TRIG_FOUND_OUT <= 1'b1;
        TRIG_DRIVE_OUT <= 1'b1;
      end
    end
  end

  // stored state count, cleared at begin, held after halt
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      STORED_COUNT_OUT <= '0;
    end else if (CE_IN) begin
      if (CMD_BEGIN_IN && !stop_cmd) begin
        STORED_COUNT_OUT <= '0;
      end else if (store) begin
        STORED_COUNT_OUT <= STORED_COUNT_OUT + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // trace memory
  // --------------------------------------------------------------------
  trc_mem_if #(.AW(AW), .W(STATE_W)) mem_bus ();

  assign mem_bus.wr_en = store;
  assign mem_bus.wr_addr = STORED_COUNT_OUT[AW-1:0];
  assign mem_bus.wr_data = cur_state;
  assign mem_bus.rd_addr = RD_ADDR_IN;
  assign RD_DATA_OUT = mem_bus.rd_data;

  trc_mem #(.AW(AW), .W(STATE_W), .DEPTH(DEPTH)) u_mem (
    .clk_in(REF_CLK_IN),
    .ce_in(CE_IN),
    .port(mem_bus.mem)
  );

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  sequence s_halt;
    CE_IN && CMD_HALT_IN;
  endsequence

  sequence s_first_trig;
    CE_IN && capture && qual && !TRIG_FOUND_OUT;
  endsequence

  a_halt_stops_run: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_halt |=> !RUNNING_OUT && !TRIG_DRIVE_OUT)
    else $error("halt did not stop the trace");
  a_trigger_store: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    s_first_trig |=> TRIG_DRIVE_OUT && STORED_COUNT_OUT == 1)
    else $error("trigger did not start storage");
  a_idle_no_store: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    !EMU_RUNNING_IN && !CMD_BEGIN_IN |=> $stable(STORED_COUNT_OUT))
    else $error("state stored while processor stopped");
  a_complete_full: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    COMPLETE_OUT |-> TRIG_FOUND_OUT && STORED_COUNT_OUT == FULL_CNT)
    else $error("complete before memory full");
  a_running_count: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    RUNNING_OUT |-> !COMPLETE_OUT &&
    ((STORED_COUNT_OUT != 0) == TRIG_FOUND_OUT))
    else $error("running status and count disagree");
  a_reset_spec: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    CE_IN && CMD_RESET_IN |=> set1_sel_reg == SET1_SEL_RST &&
    inter_and_reg == INTER_AND_RST && pat_neq_reg == PAT_NEQ_RST)
    else $error("reset command left a non-default spec");
  a_self_nor: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    set1_nor_reg && set1_sel_reg == 6'h04 |-> set1_res == !pat_hit[0])
    else $error("self nor is not the inverse");
  a_inter_op: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    !inter_and_reg && (set1_res || set2_res) |-> qual)
    else $error("between-set or lost a set result");
  a_inter_and: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    inter_and_reg && !(set1_res && set2_res) |-> !qual)
    else $error("between-set and passed a false set");
  a_neq_sense: assert property (
    @(posedge REF_CLK_IN) disable iff (RST_IN)
    pat_neq_reg[4] |-> pat_hit[4] ==
    !pat_match(cur_state, pat_val_reg[4], pat_mask_reg[4]))
    else $error("not-equal sense not applied");
endmodule
`default_nettype wire

/* File: logic/trc_mem.sv */
// trace memory: one write port, registered read port
// assumes: driven by the qualifier top through trc_mem_if
`timescale 1ns/1ps
`default_nettype none
module trc_mem #(
  parameter int AW = 10,
  parameter int W = 48,
  parameter int DEPTH = 1024
) (
  input wire logic clk_in,
  input wire logic ce_in,
  trc_mem_if.mem port
);
  logic [W-1:0] ram [DEPTH];
  logic [W-1:0] rd_reg;

  // --------------------------------------------------------------------
  // storage and read register, both frozen while the enable is low
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (ce_in && port.wr_en) begin
      ram[port.wr_addr] <= port.wr_data;
    end
    if (ce_in) begin
      rd_reg <= ram[port.rd_addr];
    end
  end

  assign port.rd_data = rd_reg;
endmodule
`default_nettype wire

/* File: logic/trc_mem_if.sv */
// carrier between the qualifier control and its trace memory
// assumes: one clock, write and read ports used by the same clock domain
`timescale 1ns/1ps
`default_nettype none
interface trc_mem_if #(
  parameter int AW = 10,
  parameter int W = 48
) ();
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data,
                output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: logic/trc_pkg.sv */
// trace qualifier package: widths, reset values and run states
// assumes: shared by the qualifier top, the bus model and the bench; its memory and the carrier interface do not import it
package trc_pkg;

  // ----------------------------------------------------------------------
  // captured state layout {stat, data, addr}
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;
  localparam int STATE_W = ADDR_W + DATA_W + STAT_W;
  localparam int ADDR_LSB = 0;
  localparam int DATA_LSB = ADDR_W;
  localparam int STAT_LSB = ADDR_W + DATA_W;

  // ----------------------------------------------------------------------
  // resources and set membership widths
  // ----------------------------------------------------------------------
  localparam int N_PAT = 8;
  localparam int PAT_IDX_W = 3;
  localparam int SET1_W = 6; // r, !r, a, b, c, d
  localparam int SET2_W = 5; // e, f, g, h, arm

  // ----------------------------------------------------------------------
  // default trace specification
  // ----------------------------------------------------------------------
  localparam logic [SET1_W-1:0] SET1_SEL_RST = 6'h04; // pattern a only
  localparam logic SET1_NOR_RST = 1'b0;
  localparam logic [SET2_W-1:0] SET2_SEL_RST = 5'h00;
  localparam logic SET2_NOR_RST = 1'b0;
  localparam logic INTER_AND_RST = 1'b0;
  localparam logic [STATE_W-1:0] PAT_VAL_RST = 48'h0;
  localparam logic [STATE_W-1:0] PAT_MASK_RST = 48'h0; // match anything
  localparam logic [N_PAT-1:0] PAT_NEQ_RST = 8'h00;
  localparam logic [ADDR_W-1:0] RANGE_LO_RST = 24'h0;
  localparam logic [ADDR_W-1:0] RANGE_HI_RST = 24'h0;

  // ----------------------------------------------------------------------
  // run control states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } run_state_t;

endpackage
